// >>> pkg/i2css_defs.vh
`ifndef I2CSS_DEFS_VH
`define I2CSS_DEFS_VH
// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define I2CSS_OFS_CTRLA 4'h9
`define I2CSS_OFS_CMDCTL 4'hA
`define I2CSS_OFS_STATUS 4'hB
`define I2CSS_OFS_ADDR 4'hC
`define I2CSS_OFS_DATA 4'hD
`define I2CSS_OFS_MCTRL 4'h3
// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define I2CSS_ST_DATA 7
`define I2CSS_ST_ADST 6
`define I2CSS_ST_HOLD 5
`define I2CSS_ST_RECEIVED_ACK 4
`define I2CSS_ST_CLASH 3
`define I2CSS_ST_FAULT 2
`define I2CSS_ST_DIR 1
`define I2CSS_ST_CAUSE 0
`define I2CSS_CA_DIRQ 7
`define I2CSS_CA_AIEN 6
`define I2CSS_CA_STOPEN 5
`define I2CSS_CA_PMEN 2
`define I2CSS_CA_SMART 1
`define I2CSS_MSB 7
`define I2CSS_CA_EN 0
`define I2CSS_CB_ACK 2
// -----------------------------------------------------------------------------
// commands and reset values
// -----------------------------------------------------------------------------
`define I2CSS_CMD_NO_ACTION_CODE 2'h0
`define I2CSS_CMD_RSVD 2'h1
`define I2CSS_CMD_COMP 2'h2
`define I2CSS_CMD_RESP 2'h3
`define I2CSS_RST8 8'h00
`define I2CSS_GCALL 7'h00
`endif

// >>> hdl/i2css_slave.v
// Functional notes
// [R1] ack action on data access or command
// [R2] ack_action is plain stored bit
// [R3] command field is strobe, reads zero
// [R4] 0 none, 1 reserved, 2 completes transaction
// [R5] 3 after address: ack then receive/data flag
// [R6] 3 after data: ack-receive or read-then-ack
// [R7] ack and command written together use new ack
// [R8] flags clear by data or command access
// [R9] data flag sets on byte done or clash
// [R10] data flag clear: w1, data access, command
// [R11] addr/stop flag: address match or stop
// [R12] hold scl low while flag set
// [R13] bit 4 holds last master ack
// [R14] clash: flag, stop driving low, finish byte
// [R15] clash on address nack sets addr flag (here never: is_addr_r is already low in S_ACK)
// [R16] clash flag clears on w1 or start
// [R17] line fault on bad start/stop, w1 clear (here only a stop straight after a start)
// [R18] fault detect only with master enabled
// [R19] direction bit from last address packet
// [R20] cause bit: 0 stop, 1 address
// [R21] addr[7:1] own address, addr[0] general call
// [R22] data irq needs flag and enable
// [R23] stop sets flag only with enable
// [R24] smart mode: data access continues operation
// [R25] reserved command changes nothing
// [R26] reset clears all, lines released
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "i2css_defs.vh"
module i2css_slave (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output wire data_irq_o,
  output wire addr_stop_irq_o
);
  // ---------------------------------------------------------------------------
  // states
  // ---------------------------------------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_RX = 3'h1;
  localparam S_TX = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_ACK = 3'h4;
  localparam S_MACK = 3'h5;
  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  reg [1:0] scl_s_r, sda_s_r;
  reg scl_d_r, sda_d_r;
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  wire scl = scl_s_r[1];
  wire sda = sda_s_r[1];
  wire scl_rise = scl & ~scl_d_r;
  wire scl_fall = ~scl & scl_d_r;
  wire start_c = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_c = scl & scl_d_r & ~sda_d_r & sda;
  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  reg [7:0] ctrla_r, own_addr_r, shift_r;
  reg mctrl_en_r, ack_action_r;
  reg data_flag_r, addr_stop_flag_r, received_ack_r, drive_clash_flag_r;
  reg line_fault_flag_r, dir_r, addr_or_stop_cause_r;
  reg [2:0] st_r;
  reg [3:0] bcnt_r;
  reg is_addr_r, sda_low_r, hold_r, was_start_r;
  wire [7:0] status = {data_flag_r, addr_stop_flag_r, hold_r, received_ack_r,
    drive_clash_flag_r, line_fault_flag_r, dir_r, addr_or_stop_cause_r};
  // ---------------------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------------------
  wire wr_cmd = wr_i && addr_i == `I2CSS_OFS_CMDCTL;
  wire [1:0] slave_command = wdata_i[1:0];
  wire cmd_ok = wr_cmd && slave_command != `I2CSS_CMD_NO_ACTION_CODE
    && slave_command != `I2CSS_CMD_RSVD; // [R25]
  wire data_acc = (wr_i || rd_i) && addr_i == `I2CSS_OFS_DATA;
  wire smart = ctrla_r[`I2CSS_CA_SMART];
  // a data write that also starts transmit must send its own first bit
  wire tx_first = (wr_i && addr_i == `I2CSS_OFS_DATA && hold_r) ?
    wdata_i[`I2CSS_MSB] : shift_r[`I2CSS_MSB];
  wire go = cmd_ok || (data_acc && smart); // [R24]
  wire flag_clr = cmd_ok || data_acc; // [R8] [R10]
  wire wr_st = wr_i && addr_i == `I2CSS_OFS_STATUS;
  // newly written ack value wins when written with a command
  wire ack_now = wr_cmd ? wdata_i[`I2CSS_CB_ACK] : ack_action_r; // [R7]
  wire complete = cmd_ok && slave_command == `I2CSS_CMD_COMP;
  function match;
    input [7:0] a;
    input [7:0] own;
    input pm;
    begin
      match = pm || a[7:1] == own[7:1]
        || (own[0] && a[7:1] == `I2CSS_GCALL); // [R21]
    end
  endfunction
  // ---------------------------------------------------------------------------
  // byte engine and flags
  // ---------------------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin // [R26]
      ctrla_r <= `I2CSS_RST8;
      own_addr_r <= `I2CSS_RST8;
      shift_r <= `I2CSS_RST8;
      mctrl_en_r <= 1'b0;
      ack_action_r <= 1'b0;
      data_flag_r <= 1'b0;
      addr_stop_flag_r <= 1'b0;
      received_ack_r <= 1'b0;
      drive_clash_flag_r <= 1'b0;
      line_fault_flag_r <= 1'b0;
      dir_r <= 1'b0;
      addr_or_stop_cause_r <= 1'b0;
      st_r <= S_IDLE;
      bcnt_r <= 4'h0;
      is_addr_r <= 1'b0;
      sda_low_r <= 1'b0;
      hold_r <= 1'b0;
      was_start_r <= 1'b0;
    end else begin
      if (wr_i && addr_i == `I2CSS_OFS_CTRLA)
        ctrla_r <= wdata_i;
      if (wr_i && addr_i == `I2CSS_OFS_ADDR)
        own_addr_r <= wdata_i;
      if (wr_i && addr_i == `I2CSS_OFS_MCTRL)
        mctrl_en_r <= wdata_i[0];
      if (wr_cmd)
        ack_action_r <= wdata_i[`I2CSS_CB_ACK]; // [R2]
      if (wr_i && addr_i == `I2CSS_OFS_DATA && hold_r)
        shift_r <= wdata_i;
      // clears first, hardware sets below win
      if (flag_clr || (wr_st && wdata_i[`I2CSS_ST_DATA]))
        data_flag_r <= 1'b0; // [R10]
      if (flag_clr || (wr_st && wdata_i[`I2CSS_ST_ADST]))
        addr_stop_flag_r <= 1'b0; // [R11]
      if (wr_st && wdata_i[`I2CSS_ST_CLASH])
        drive_clash_flag_r <= 1'b0; // [R16]
      if (wr_st && wdata_i[`I2CSS_ST_FAULT])
        line_fault_flag_r <= 1'b0; // [R17]
      if (hold_r && go)
        hold_r <= 1'b0; // [R12]
      if (st_r != S_IDLE && start_c)
        was_start_r <= 1'b1;
      if (scl_fall)
        was_start_r <= 1'b0;
      // bus error: stop straight after start, detector lives with master
      if (mctrl_en_r && stop_c && was_start_r)
        line_fault_flag_r <= 1'b1; // [R17] [R18]
      if (start_c) begin
        drive_clash_flag_r <= 1'b0; // [R16]
        was_start_r <= 1'b1;
        if (ctrla_r[`I2CSS_CA_EN]) begin
          st_r <= S_RX;
          is_addr_r <= 1'b1;
          bcnt_r <= 4'h0;
          sda_low_r <= 1'b0;
          hold_r <= 1'b0;
        end
      end else if (stop_c) begin
        st_r <= S_IDLE;
        sda_low_r <= 1'b0;
        hold_r <= 1'b0;
        if (ctrla_r[`I2CSS_CA_STOPEN] && ctrla_r[`I2CSS_CA_EN]) begin
          addr_stop_flag_r <= 1'b1; // [R23]
          addr_or_stop_cause_r <= 1'b0; // [R20]
        end
      end else begin
        case (st_r)
          S_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda};
              bcnt_r <= bcnt_r + 4'h1;
            end
            if (scl_fall && bcnt_r == 4'h8) begin
              bcnt_r <= 4'h0;
              if (is_addr_r) begin
                if (match(shift_r, own_addr_r, ctrla_r[`I2CSS_CA_PMEN])) begin
                  dir_r <= shift_r[0]; // [R19]
                  addr_stop_flag_r <= 1'b1; // [R11]
                  addr_or_stop_cause_r <= 1'b1; // [R20]
                  hold_r <= 1'b1; // [R12]
                  st_r <= S_HOLD;
                end else begin
                  st_r <= S_IDLE;
                end
              end else begin
                data_flag_r <= 1'b1; // [R9]
                hold_r <= 1'b1; // [R12]
                st_r <= S_HOLD;
              end
            end
          end
          S_HOLD: begin
            if (complete) begin
              // master write acks then idles; master read only idles
              sda_low_r <= ~dir_r & ~ack_now; // [R4] [R1]
              st_r <= dir_r ? S_IDLE : S_ACK;
              is_addr_r <= 1'b0;
              bcnt_r <= 4'h1;
            end else if (go) begin
              if (dir_r && is_addr_r) begin
                sda_low_r <= ~ack_now; // [R5] [R1]
                st_r <= S_ACK;
                bcnt_r <= 4'h2;
              end else if (dir_r) begin
                st_r <= S_TX; // [R6]
                sda_low_r <= ~tx_first;
                bcnt_r <= 4'h0;
              end else begin
                sda_low_r <= ~ack_now; // [R5] [R6] [R1]
                st_r <= S_ACK;
                bcnt_r <= 4'h0;
              end
              is_addr_r <= 1'b0;
            end
          end
          S_ACK: begin
            // nack not seen on the line means another node pulled low
            if (scl_rise && ~sda_low_r && ~sda && ack_now) begin
              drive_clash_flag_r <= 1'b1; // [R14]
              if (is_addr_r)
                addr_stop_flag_r <= 1'b1; // [R15]
            end
            if (scl_fall) begin
              sda_low_r <= 1'b0;
              case (bcnt_r)
                4'h1: st_r <= S_IDLE;
                4'h2: begin
                  data_flag_r <= 1'b1; // [R5]
                  hold_r <= 1'b1;
                  st_r <= S_HOLD;
                end
                default: st_r <= S_RX;
              endcase
            end
          end
          S_TX: begin
            if (scl_rise) begin
              if (~sda_low_r && ~sda)
                drive_clash_flag_r <= 1'b1; // [R14]
              shift_r <= {shift_r[6:0], 1'b1};
              bcnt_r <= bcnt_r + 4'h1;
            end
            if (scl_fall) begin
              sda_low_r <= (bcnt_r == 4'h8) ? 1'b0 : ~shift_r[7];
              if (bcnt_r == 4'h8)
                st_r <= S_MACK;
            end
          end
          S_MACK: begin
            if (scl_rise)
              received_ack_r <= sda; // [R13]
            if (scl_fall) begin
              data_flag_r <= 1'b1; // [R9] [R6]
              hold_r <= 1'b1;
              st_r <= S_HOLD;
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------------------
  // pins, interrupts, read port
  // ---------------------------------------------------------------------------
  assign scl_o = 1'b0;
  assign scl_oe_o = hold_r; // [R12]
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_r & ~drive_clash_flag_r; // [R14]
  assign data_irq_o = data_flag_r & ctrla_r[`I2CSS_CA_DIRQ]; // [R22]
  assign addr_stop_irq_o = addr_stop_flag_r & ctrla_r[`I2CSS_CA_AIEN]
    & ctrla_r[`I2CSS_CA_STOPEN]; // [R23]
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= `I2CSS_RST8;
    end else if (rd_i) begin
      case (addr_i)
        `I2CSS_OFS_CTRLA: rdata_o <= ctrla_r;
        `I2CSS_OFS_CMDCTL: rdata_o <= {5'h00, ack_action_r, 2'h0}; // [R3]
        `I2CSS_OFS_STATUS: rdata_o <= status;
        `I2CSS_OFS_ADDR: rdata_o <= own_addr_r;
        `I2CSS_OFS_DATA: rdata_o <= shift_r;
        `I2CSS_OFS_MCTRL: rdata_o <= {7'h00, mctrl_en_r};
        default: rdata_o <= `I2CSS_RST8;
      endcase
    end else begin
      rdata_o <= `I2CSS_RST8;
    end
  end
endmodule // i2css_slave
`default_nettype wire

// >>> tb/i2css_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// far-side bus master, open drain
// ----
module i2css_bus_master #(
  parameter int HALF = 12
) (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic tmo_o
);
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    tmo_o = 1'b0;
  end
  task automatic hp;
    repeat (HALF) @(posedge clk_i);
  endtask
  // stretch is honoured, but a stuck clock is flagged, not waited forever
  task automatic rise;
    int i;
    scl_oe_o <= 1'b0;
    for (i = 0; i < 4000 && scl_i !== 1'b1; i++) @(posedge clk_i);
    if (scl_i !== 1'b1) tmo_o <= 1'b1;
    hp;
  endtask
  task automatic start;
    @(posedge clk_i);
    sda_oe_o <= 1'b0;
    rise;
    sda_oe_o <= 1'b1;
    hp;
    scl_oe_o <= 1'b1;
  endtask
  task automatic stop;
    @(posedge clk_i);
    sda_oe_o <= 1'b1;
    hp;
    rise;
    sda_oe_o <= 1'b0;
    hp;
  endtask
  // sda moves one edge after scl falls so no false start or stop is seen
  task automatic bit_w(input logic b);
    @(posedge clk_i);
    sda_oe_o <= !b;
    hp;
    rise;
    scl_oe_o <= 1'b1;
  endtask
  task automatic bit_r(output logic b);
    @(posedge clk_i);
    sda_oe_o <= 1'b0;
    hp;
    rise;
    b = sda_i;
    scl_oe_o <= 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_w(d[i]);
    bit_r(ack);
  endtask
  task automatic rbyte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) bit_r(d[i]);
    bit_w(nack);
  endtask
endmodule // i2css_bus_master
`default_nettype wire

// >>> tb/i2css_slave_chk.sv
`timescale 1ns/10ps
`default_nettype none
module i2css_slave_chk (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe_o,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire data_irq_o,
  input wire addr_stop_irq_o
);
  // ----
  // shadows of written control bits
  // ----
  logic ack_r, men_r;
  logic [7:0] ctl_r;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      men_r <= 1'b0;
      ctl_r <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == 4'hA) ack_r <= wdata_i[2];
      if (addr_i == 4'h9) ctl_r <= wdata_i;
      if (addr_i == 4'h3) men_r <= men_r | wdata_i[0];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_lines: assert property ($rose(rst_n_i) |-> !scl_oe_o && !sda_oe_o)
    else $error("bus lines driven after reset");
  a_ack_bit_holds: assert property (rd_i && addr_i == 4'hA |=> rdata_o[2] == ack_r)
    else $error("ack action bit lost");
  a_cmd_reads_zero: assert property (rd_i && addr_i == 4'hA |=> rdata_o[1:0] == 2'b00)
    else $error("command field reads nonzero");
  a_hold_mirrors_scl: assert property (rd_i && addr_i == 4'hB |=> rdata_o[5] == $past(scl_oe_o))
    else $error("hold bit differs from scl drive");
  a_data_irq_gate: assert property (rd_i && addr_i == 4'hB |=>
    (rdata_o[7] && ctl_r[7]) == $past(data_irq_o)) else $error("data irq gating wrong");
  a_addr_irq_gate: assert property (rd_i && addr_i == 4'hB |=>
    (rdata_o[6] && ctl_r[6] && ctl_r[5]) == $past(addr_stop_irq_o)) else $error("addr irq wrong");
  a_fault_needs_master: assert property (rd_i && addr_i == 4'hB && !men_r |=> !rdata_o[2])
    else $error("line fault without master enable");
  a_data_access_clear: assert property ((wr_i || rd_i) && addr_i == 4'hD && scl_oe_o |=>
    !data_irq_o) else $error("data flag not cleared by access");
  a_reserved_keeps: assert property (wr_i && addr_i == 4'hA && wdata_i[1:0] == 2'b01 |=>
    $stable(data_irq_o) && $stable(addr_stop_irq_o)) else $error("reserved command changed flags");
  c_hold_read: cover property (rd_i && addr_i == 4'hB && scl_oe_o);
  c_data_irq: cover property (data_irq_o);
  c_addr_irq: cover property (addr_stop_irq_o);
endmodule // i2css_slave_chk
bind i2css_slave i2css_slave_chk chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .data_irq_o(data_irq_o), .addr_stop_irq_o(addr_stop_irq_o));
`default_nettype wire

// >>> tb/i2c_slave_command_status_test.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_command_status_test;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, oa, d1, d2, rb;
  logic [16:0] seed = 17'h16F85;
  logic [15:0] note;
  logic m_scl, m_sda, tmo, s_scl, s_sda, ack;
  logic [15:0] exp_q[$];
  int n_fail = 0, n_tests = 0;
  // ----
  // open-drain wires with pull-ups
  // ----
  wire scl = !(m_scl || s_scl);
  wire sda = !(m_sda || s_sda);
  always #2 clk = ~clk;
  i2css_slave dut_u (.mclk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .scl_i(scl), .scl_o(), .scl_oe_o(s_scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(s_sda), .data_irq_o(), .addr_stop_irq_o());
  i2css_bus_master mm_u (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl),
    .sda_oe_o(m_sda), .tmo_o(tmo));
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // waits for a fresh stretch, so a stale hold is never mistaken for a new one
  task automatic hold;
    int i;
    for (i = 0; i < 5000 && s_scl === 1'b1; i++) @(posedge clk);
    for (i = 0; i < 5000 && s_scl !== 1'b1; i++) @(posedge clk);
    chk({7'h00, s_scl}, 8'h01);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d) begin
      note = exp_q.pop_front();
      chk(rdata & note[15:8], note[7:0]);
    end
    rd_d <= rd;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    seed = nxt(seed);
    oa = {2'b01, seed[4:0], 1'b0};
    seed = nxt(nxt(seed));
    d1 = seed[7:0];
    seed = nxt(nxt(nxt(seed)));
    d2 = seed[7:0];
    rdr(4'hB, 8'h00, 8'hFF);
    rdr(4'hC, 8'h00, 8'hFF);
    rdr(4'hF, 8'h00, 8'hFF);
    wrr(4'hC, oa);
    rdr(4'hC, oa, 8'hFF);
    wrr(4'h9, 8'hE3);
    wrr(4'hA, 8'h04);
    rdr(4'hA, 8'h04, 8'hFF);
    fork
      begin
        mm_u.start();
        mm_u.wbyte(oa, ack);
      end
      begin
        hold();
        rdr(4'hB, 8'h61, 8'hFF);
        wrr(4'hA, 8'h05);
        rdr(4'hB, 8'h61, 8'hFF);
        wrr(4'hA, 8'h03);
      end
    join
    chk({7'h00, ack}, 8'h00);
    fork
      mm_u.wbyte(d1, ack);
      begin
        hold();
        rdr(4'hB, 8'hA0, 8'hE0);
        rdr(4'hD, d1, 8'hFF);
      end
    join
    chk({7'h00, ack}, 8'h00);
    rdr(4'hB, 8'h00, 8'hE0);
    mm_u.stop();
    rdr(4'hB, 8'h40, 8'h41);
    fork
      begin
        mm_u.start();
        mm_u.wbyte(oa | 8'h01, ack);
        mm_u.rbyte(rb, 1'b1);
      end
      begin
        hold();
        rdr(4'hB, 8'h63, 8'hFF);
        wrr(4'hA, 8'h03);
        hold();
        rdr(4'hB, 8'hA2, 8'hE2);
        wrr(4'hD, d2);
        hold();
        rdr(4'hB, 8'hB2, 8'hF2);
        wrr(4'hA, 8'h02);
      end
    join
    chk(rb, d2);
    chk({7'h00, ack}, 8'h00);
    mm_u.stop();
    chk({7'h00, tmo}, 8'h00);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule // i2c_slave_command_status_test
`default_nettype wire
